//--- rtl/rto_pkg.sv
package rto_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned NBITS = 6;
  localparam int unsigned HALF = 3;
  localparam int unsigned AW = 12;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CTRL = 12'h000;
  localparam logic [AW-1:0] OFS_BUF_LOW = 12'h004;
  localparam logic [AW-1:0] OFS_BUF_HIGH = 12'h008;
  localparam logic [AW-1:0] OFS_MASK = 12'h00c;
  localparam logic [AW-1:0] OFS_SHUT = 12'h010;
  localparam logic [AW-1:0] OFS_PDATA = 12'h014;
  localparam logic [AW-1:0] OFS_PDIR = 12'h018;
  localparam logic [AW-1:0] OFS_PMC = 12'h01c;
  localparam logic [AW-1:0] OFS_PUP = 12'h020;
  localparam logic [AW-1:0] OFS_PFC = 12'h024;
  localparam logic [AW-1:0] OFS_PFN = 12'h028;
  localparam logic [AW-1:0] OFS_STAT = 12'h02c;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_TSEL_LO = 1; // 2-bit trigger select
  localparam int unsigned SHUT_EN_BIT = 0;
  localparam int unsigned SHUT_EDGE_LO = 1; // 2-bit edge select
  localparam int unsigned SHUT_KEEP_W = 3;  // bits 2:0 stored, bit 3 ignored
  // ---------------------------------------------------------------
  // reset values of port registers
  // ---------------------------------------------------------------
  localparam logic [NBITS-1:0] RST_PDATA = 6'h00;
  localparam logic [NBITS-1:0] RST_PDIR = 6'h3f;
  localparam logic [NBITS-1:0] RST_PMC = 6'h00;
  localparam logic [NBITS-1:0] RST_PUP = 6'h00;
  localparam logic [NBITS-1:0] RST_PFC = 6'h00;
  localparam logic [NBITS-1:0] RST_PFN = 6'h00;
  // ---------------------------------------------------------------
  // edge select codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    edge_none_type = 2'h0,
    edge_rise_type = 2'h1,
    edge_fall_type = 2'h2,
    edge_both_type = 2'h3
  } edge_sel_type;
endpackage

//--- rtl/rto_bus_if.sv
`timescale 1ns/100ps
// read and write strobes, address and data between bus slave and core
interface rto_bus_if;
  logic wr;
  logic rd;
  logic [rto_pkg::AW-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slave (output wr, output rd, output addr, output wdata, input rdata);
  modport core (input wr, input rd, input addr, input wdata, output rdata);
endinterface

//--- rtl/rto_apb_slave.sv
`timescale 1ns/100ps
module rto_apb_slave (
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rto_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  rto_bus_if.slave bus
);
  import rto_pkg::*;
  // ---------------------------------------------------------------
  // zero-wait access phase, word aligned
  // ---------------------------------------------------------------
  wire access = psel & penable;
  assign bus.wr = access & pwrite;
  assign bus.rd = access & ~pwrite;
  assign bus.addr = paddr;
  assign bus.wdata = pwdata;
  assign prdata = bus.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
endmodule

//--- rtl/rto_port.sv
`timescale 1ns/100ps
// Notes on behaviour
// - pin carries real-time output only when configured
// - selected shutdown edge floats all pins while shutdown enable is set
// - shutdown restores port register initial values
// - clearing shutdown enable unlocks port config
// - disabled output drives all real-time output bits zero
// - buffer write passes to latch when disabled
module rto_port
#(
  parameter int unsigned WIDTH = rto_pkg::NBITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rto_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trig_a,
  input wire logic trig_b,
  input wire logic trig_c,
  input wire logic shutdown_irq_input,
  input wire logic [WIDTH-1:0] port5_pin_in,
  output logic [WIDTH-1:0] port5_pin_out,
  output logic [WIDTH-1:0] port5_pin_oe,
  output logic [WIDTH-1:0] port5_pullup_en,
  output logic shutdown_irq
);
  import rto_pkg::*;
  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  rto_bus_if bus ();
  rto_apb_slave u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bus(bus.slave)
  );

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic en_r;
  logic [1:0] tsel_r;
  logic [WIDTH-1:0] mask_r, buf_r, latch_r;
  logic shut_en_r;
  logic [1:0] shut_edge_r;
  logic shut_r;
  logic [WIDTH-1:0] pdata_r, pdir_r, pmc_r, pup_r, pfc_r, pfn_r;
  logic [2:0] sync_r;
  logic [WIDTH-1:0] pin_s1_r, pin_s2_r;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    hit = (a == ofs);
  endfunction
  wire wr_ctrl = bus.wr & hit(bus.addr, OFS_CTRL);
  wire wr_lo = bus.wr & hit(bus.addr, OFS_BUF_LOW);
  wire wr_hi = bus.wr & hit(bus.addr, OFS_BUF_HIGH);
  wire wr_mask = bus.wr & hit(bus.addr, OFS_MASK);
  wire wr_shut = bus.wr & hit(bus.addr, OFS_SHUT);
  wire [WIDTH-1:0] wd = bus.wdata[WIDTH-1:0];
  wire [31:0] wd32 = bus.wdata;

  // ---------------------------------------------------------------
  // shutdown edge detection
  // ---------------------------------------------------------------
  wire irq_s = sync_r[1];
  wire irq_d = sync_r[2];
  wire rise = irq_s & ~irq_d;
  wire fall = ~irq_s & irq_d;
  wire edge_hit = ((shut_edge_r == edge_rise_type) & rise) |
                  ((shut_edge_r == edge_fall_type) & fall) |
                  ((shut_edge_r == edge_both_type) & (rise | fall));
  wire shut_evt = shut_en_r & edge_hit;
  assign shutdown_irq = edge_hit;
  wire shut_clear = wr_shut & ~wd32[SHUT_EN_BIT];
  // port config writable only when not shut down
  wire cfg_wr = bus.wr & ~shut_r;

  // ---------------------------------------------------------------
  // trigger select
  // ---------------------------------------------------------------
  wire trig = (tsel_r == 2'h0) ? trig_a :
              (tsel_r == 2'h1) ? trig_b :
              (tsel_r == 2'h2) ? trig_c : 1'b0;

  // ---------------------------------------------------------------
  // buffer and latch paths
  // ---------------------------------------------------------------
  wire [HALF-1:0] lo_w = wd[HALF-1:0];
  wire [HALF-1:0] hi_w = wd[HALF-1:0];
  logic [WIDTH-1:0] buf_nxt, latch_nxt;
  always_comb begin
    buf_nxt = buf_r;
    if (wr_lo) begin
      buf_nxt[HALF-1:0] = lo_w;
    end
    if (wr_hi) begin
      buf_nxt[WIDTH-1:HALF] = hi_w;
    end
    latch_nxt = latch_r;
    if (!en_r) begin
      latch_nxt = buf_nxt;
    end else if (trig) begin
      latch_nxt = (buf_r & mask_r) | (latch_r & ~mask_r);
    end
  end

  // control, buffer and latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
      tsel_r <= 2'h0;
      mask_r <= '0;
      buf_r <= '0;
      latch_r <= '0;
    end else begin
      if (wr_ctrl) begin
        en_r <= wd32[CTRL_EN_BIT];
        tsel_r <= wd32[CTRL_TSEL_LO +: 2];
      end
      if (wr_mask) begin
        mask_r <= wd;
      end
      buf_r <= buf_nxt;
      latch_r <= latch_nxt;
    end
  end

  // shutdown control and input synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_r <= 3'h0;
      shut_en_r <= 1'b0;
      shut_edge_r <= 2'h0;
      shut_r <= 1'b0;
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      sync_r <= {sync_r[1:0], shutdown_irq_input};
      pin_s1_r <= port5_pin_in;
      pin_s2_r <= pin_s1_r;
      if (wr_shut) begin
        shut_en_r <= wd32[SHUT_EN_BIT];
        shut_edge_r <= wd32[SHUT_EDGE_LO +: 2];
      end
      // a fresh edge wins over a clear in the same cycle
      if (shut_evt) begin
        shut_r <= 1'b1;
      end else if (shut_clear) begin
        shut_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // port configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdata_r <= RST_PDATA;
      pdir_r <= RST_PDIR;
      pmc_r <= RST_PMC;
      pup_r <= RST_PUP;
      pfc_r <= RST_PFC;
      pfn_r <= RST_PFN;
    end else if (shut_evt || shut_r) begin
      pdata_r <= RST_PDATA;
      pdir_r <= RST_PDIR;
      pmc_r <= RST_PMC;
      pup_r <= RST_PUP;
      pfc_r <= RST_PFC;
      pfn_r <= RST_PFN;
    end else if (cfg_wr) begin
      if (hit(bus.addr, OFS_PDATA)) pdata_r <= wd;
      if (hit(bus.addr, OFS_PDIR)) pdir_r <= wd;
      if (hit(bus.addr, OFS_PMC)) pmc_r <= wd;
      if (hit(bus.addr, OFS_PUP)) pup_r <= wd;
      if (hit(bus.addr, OFS_PFC)) pfc_r <= wd;
      if (hit(bus.addr, OFS_PFN)) pfn_r <= wd;
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // disabled output forces zero
  wire [WIDTH-1:0] rto_signal = en_r ? (latch_r & mask_r) : '0;
  wire [WIDTH-1:0] rto_sel = pmc_r & pfc_r;
  assign port5_pin_oe = shut_r ? '0 : (rto_sel | (~pmc_r & ~pdir_r));
  assign port5_pin_out = (rto_signal & rto_sel) | (pdata_r & ~rto_sel);
  assign port5_pullup_en = pup_r & ~port5_pin_oe;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  function automatic logic [31:0] zx(input logic [WIDTH-1:0] v);
    zx = {{(32-WIDTH){1'b0}}, v};
  endfunction
  assign bus.rdata =
    hit(bus.addr, OFS_CTRL) ? {29'h0, tsel_r, en_r} :
    hit(bus.addr, OFS_BUF_LOW) ? {29'h0, buf_r[HALF-1:0]} :
    hit(bus.addr, OFS_BUF_HIGH) ? {29'h0, buf_r[WIDTH-1:HALF]} :
    hit(bus.addr, OFS_MASK) ? zx(mask_r) :
    hit(bus.addr, OFS_SHUT) ? {29'h0, shut_edge_r, shut_en_r} :
    hit(bus.addr, OFS_PDATA) ? zx(pin_s2_r) :
    hit(bus.addr, OFS_PDIR) ? zx(pdir_r) :
    hit(bus.addr, OFS_PMC) ? zx(pmc_r) :
    hit(bus.addr, OFS_PUP) ? zx(pup_r) :
    hit(bus.addr, OFS_PFC) ? zx(pfc_r) :
    hit(bus.addr, OFS_PFN) ? zx(pfn_r) :
    hit(bus.addr, OFS_STAT) ? {20'h0, latch_r, 5'h0, shut_r} : 32'h0;
endmodule

//--- verif/rto_checker.sv
`timescale 1ns/100ps
module rto_checker
  import rto_pkg::*;
#(
  parameter int unsigned WIDTH = rto_pkg::NBITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rto_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [WIDTH-1:0] port5_pin_oe,
  input wire logic [WIDTH-1:0] port5_pullup_en,
  input wire logic shutdown_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // -------------------------------------------------
  // shadow of shutdown enable and latch
  // -------------------------------------------------
  logic en_r;
  logic lat_r;
  wire acc = psel & penable;
  wire sw = acc & pwrite & (paddr == OFS_SHUT);
  wire rd = acc & ~pwrite;
  // track shutdown state from bus writes and shutdown_irq
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
      lat_r <= 1'b0;
    end else begin
      if (sw) en_r <= pwdata[0];
      if (shutdown_irq && en_r) lat_r <= 1'b1;
      else if (sw && !pwdata[0]) lat_r <= 1'b0;
    end
  end
  a_shut_hiz: assert property (shutdown_irq && en_r |-> ##[1:3] port5_pin_oe == '0)
    else $error("pins still driven after shutdown");
  a_shut_hold: assert property (lat_r && $past(lat_r) && $past(lat_r, 2)
    |-> port5_pin_oe == '0 && port5_pullup_en == '0)
    else $error("config not cleared while shut");
  a_zero_wait: assert property (acc |-> pready)
    else $error("no ready in access");
  a_no_error: assert property (pslverr == 1'b0)
    else $error("error response seen");
  a_irq_pulse: assert property (shutdown_irq |=> !shutdown_irq)
    else $error("irq pulse too long");
  a_shut_bits: assert property (rd && paddr == OFS_SHUT |-> prdata[31:3] == '0)
    else $error("upper shutdown bits read set");
  a_unmapped_zero: assert property (rd && paddr > OFS_STAT |-> prdata == '0)
    else $error("unmapped read not zero");
  a_stat_flag: assert property (rd && paddr == OFS_STAT && lat_r == $past(lat_r)
    |-> prdata[0] == lat_r)
    else $error("status flag wrong");
endmodule
bind rto_port rto_checker #(.WIDTH(WIDTH)) i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .port5_pin_oe(port5_pin_oe),
  .port5_pullup_en(port5_pullup_en), .shutdown_irq(shutdown_irq));

//--- verif/rto_pin_model.sv
`timescale 1ns/100ps
module rto_pin_model (
  input wire logic pclk,
  input wire logic irq_lvl,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] pullup_en,
  output logic shutdown_irq_input,
  output logic [5:0] pin_in
);
  logic [5:0] last_r;
  initial last_r = 6'h00;
  // remember the level each pin last had while driven
  always @(posedge pclk) begin
    last_r <= (pin_oe & pin_out) | (~pin_oe & last_r);
  end
  // released pin shows pull-up, else inverse of last level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pullup_en) | (~pin_oe & ~pullup_en & ~last_r);
  assign shutdown_irq_input = irq_lvl;
endmodule

//--- verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  import rto_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, irq;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, sirq, pin_irq;
  logic [2:0] tg;
  logic [5:0] pin_in, pout, poe, pup;
  int miscompares, total_checks, cyc, n;
  rto_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_a(tg[0]), .trig_b(tg[1]), .trig_c(tg[2]),
    .shutdown_irq_input(pin_irq), .port5_pin_in(pin_in), .port5_pin_out(pout),
    .port5_pin_oe(poe), .port5_pullup_en(pup), .shutdown_irq(sirq));
  rto_pin_model i_pins (.pclk(pclk), .irq_lvl(irq), .pin_out(pout), .pin_oe(poe),
    .pullup_en(pup), .shutdown_irq_input(pin_irq), .pin_in(pin_in));
  // -------------------------------------------------
  // tasks
  // -------------------------------------------------
  task automatic xfer(input logic [AW-1:0] a, input logic [31:0] d, input logic w);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      r = prdata;
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [AW-1:0] a, input logic [31:0] e);
    xfer(a, 0, 1'b0);
    chk(r, e);
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge pclk);
    tg <= v;
    @(posedge pclk);
    tg <= 3'h0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // clock and hang guard
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      wrap_up;
    end
  end
  // -------------------------------------------------
  // main sequence
  // -------------------------------------------------
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    irq = 0;
    tg = 3'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFS_PDIR, 32'h3f);
    rdc(OFS_STAT, 32'h0);
    rdc(12'h030, 32'h0);
    $display("test reset done");
    xfer(OFS_PMC, 32'h3f, 1'b1);
    xfer(OFS_PFC, 32'h3f, 1'b1);
    for (int s = 0; s < 3; s++) begin
      xfer(OFS_CTRL, 0, 1'b1);
      xfer(OFS_MASK, 32'h3f, 1'b1);
      chk(32'(pout), 0);
      xfer(OFS_BUF_LOW, s + 1, 1'b1);
      xfer(OFS_BUF_HIGH, 0, 1'b1);
      rdc(OFS_STAT, (s + 1) << 6);
      xfer(OFS_CTRL, 1 | (s << 1), 1'b1);
      xfer(OFS_BUF_HIGH, 7, 1'b1);
      rdc(OFS_STAT, (s + 1) << 6);
      pulse(3'(1 << ((s + 1) % 3)));
      rdc(OFS_STAT, (s + 1) << 6);
      pulse(3'(1 << s));
      rdc(OFS_STAT, (56 + s + 1) << 6);
      chk(32'(pout), 56 + s + 1);
    end
    rdc(OFS_PDATA, 32'h3b);
    xfer(OFS_MASK, 32'h07, 1'b1);
    xfer(OFS_BUF_LOW, 0, 1'b1);
    pulse(3'h4);
    rdc(OFS_STAT, 32'h38 << 6);
    chk(32'(pout), 0);
    xfer(OFS_MASK, 32'h3f, 1'b1);
    xfer(OFS_PMC, 32'h38, 1'b1);
    xfer(OFS_PDATA, 32'h05, 1'b1);
    xfer(OFS_PDIR, 0, 1'b1);
    chk(32'(pout), 32'h3d);
    rdc(OFS_PDATA, 32'h3d);
    $display("test trigger done");
    xfer(OFS_SHUT, 32'h2, 1'b1);
    xfer(OFS_SHUT, 32'h3, 1'b1);
    @(posedge pclk) irq <= 1'b1;
    for (n = 0; n < 10 && sirq !== 1'b1; n++) @(posedge pclk);
    chk(n < 10, 1);
    repeat (3) @(posedge pclk);
    chk(32'(poe), 0);
    rdc(OFS_PMC, 0);
    rdc(OFS_PFC, 0);
    rdc(OFS_PDIR, 32'h3f);
    rdc(OFS_PDATA, 32'h02);
    xfer(OFS_PMC, 32'h3f, 1'b1);
    rdc(OFS_PMC, 0);
    xfer(OFS_SHUT, 32'hb, 1'b1);
    rdc(OFS_SHUT, 32'h3);
    xfer(OFS_STAT, 0, 1'b0);
    chk(r[0], 1);
    xfer(OFS_SHUT, 0, 1'b1);
    irq <= 1'b0;
    xfer(OFS_STAT, 0, 1'b0);
    chk(r[0], 0);
    xfer(OFS_SHUT, 32'h2, 1'b1);
    xfer(OFS_SHUT, 32'h3, 1'b1);
    xfer(OFS_PMC, 32'h3f, 1'b1);
    rdc(OFS_PMC, 32'h3f);
    xfer(OFS_PFC, 32'h3f, 1'b1);
    xfer(OFS_SHUT, 32'h4, 1'b1);
    xfer(OFS_SHUT, 32'h5, 1'b1);
    @(posedge pclk) irq <= 1'b1;
    repeat (6) @(posedge pclk);
    rdc(OFS_PMC, 32'h3f);
    chk(32'(poe), 32'h3f);
    irq <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'(poe), 0);
    rdc(OFS_STAT, (32'h38 << 6) | 32'h1);
    $display("test shutdown done");
    wrap_up;
  end
endmodule
